/* hw/sdc_core.sv */
// Purpose: command decode, bank states, clock enable modes and data path of a four-bank SDRAM
// Assumes: host pins sampled on CLK; BURST_LEN >= 2; CAS_LAT >= 2
// Notes:   rows are not stored; cells are addressed by bank and column only
`default_nettype none

module sdc_core #(
   parameter int BURST_LEN = 4,  // Programmed burst length
   parameter int CAS_LAT   = 2   // Programmed column-strobe latency
) (
   // Clock and reset
   input  wire logic                          CLK,
   input  wire logic                          NRST,
   // Command pins
   input  wire logic                          CKE,
   input  wire logic                          CS_N,
   input  wire logic                          RAS_N,
   input  wire logic                          CAS_N,
   input  wire logic                          WE_N,
   input  wire logic [sdc_pkg::BA_W-1:0]      BA,
   input  wire logic [sdc_pkg::ADDR_W-1:0]    ADDR,
   // Data pins
   input  wire logic [sdc_pkg::BYTES-1:0]     DQM,
   input  wire logic [sdc_pkg::DATA_W-1:0]    DQ_IN,
   output logic      [sdc_pkg::DATA_W-1:0]    DQ_OUT,
   output logic      [sdc_pkg::BYTES-1:0]     DQ_OE,
   // Status
   output logic                               ILLEGAL_CMD,
   output logic                               SELF_REFRESH,
   output logic                               POWER_DOWN,
   output logic                               WBUF_READY
);

   localparam int LEN_W = $clog2(BURST_LEN + 1);
   localparam int WB_W  = $bits(sdc_pkg::sdc_wbuf_t);

   // Reset release
   logic rst_meta_reg;
   logic rst_n_reg;

   // Mode and command
   logic                       cke_prev_reg;
   sdc_pkg::sdc_dev_t          dev_reg;
   logic [sdc_pkg::CNT_W-1:0]  dev_cnt_reg;
   sdc_pkg::sdc_cmd_t          cmd;
   logic                       idle_cmd;
   logic                       normal;
   logic                       hold;
   logic                       live;
   logic                       wake;
   logic                       bad;
   logic                       go;

   // Bank views
   sdc_pkg::sdc_bank_t         bank_st [sdc_pkg::BANKS];
   logic [sdc_pkg::BANKS-1:0]  idle_mask;
   logic [sdc_pkg::BANKS-1:0]  ap_mask;
   logic [sdc_pkg::BANKS-1:0]  no_col_mask;
   logic [sdc_pkg::BANKS-1:0]  pre_hit;
   logic                       all_idle;

   // Burst engine
   logic                       bst_active_reg;
   logic                       bst_write_reg;
   logic                       bst_ap_reg;
   logic [sdc_pkg::BA_W-1:0]   bst_bank_reg;
   logic [sdc_pkg::COL_W-1:0]  bst_col_reg;
   logic [LEN_W-1:0]           bst_left_reg;
   logic                       start;
   logic                       stop_hit;
   logic                       pre_cut;
   logic                       bst_end;

   // Column access of this cycle
   logic                       acc_v;
   logic                       acc_wr;
   logic [sdc_pkg::BA_W-1:0]   acc_bank;
   logic [sdc_pkg::COL_W-1:0]  acc_col;
   logic                       rd_issue;

   // Write buffer and read pipe
   sdc_pkg::sdc_wbuf_t         wb_in;
   sdc_pkg::sdc_wbuf_t         wb_out;
   logic [WB_W-1:0]            wb_out_bits;
   logic                       wb_in_valid;
   logic                       wb_out_valid;
   logic                       drain;
   logic [sdc_pkg::DATA_W-1:0] mem [sdc_pkg::BANKS << sdc_pkg::COL_W];
   logic [sdc_pkg::DATA_W-1:0] rd_data_reg [CAS_LAT];
   logic [CAS_LAT-1:0]         rd_v_reg;
   logic [sdc_pkg::BYTES-1:0]  dqm_d1_reg;
   logic [sdc_pkg::BYTES-1:0]  dqm_d2_reg;

   // Reset leaves through two flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // Strobe decode; chip select high masks the rest
   assign cmd = CS_N ? sdc_pkg::CMD_DESEL : sdc_pkg::sdc_cmd_t'({1'b0, RAS_N, CAS_N, WE_N});
   assign idle_cmd = (cmd == sdc_pkg::CMD_NOP) || (cmd == sdc_pkg::CMD_DESEL);

   // Clock enable seen one edge late gives the one-clock entry and exit
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cke_prev_reg <= sdc_pkg::CKE_PREV_RST;
      end else begin
         cke_prev_reg <= CKE;
      end
   end

   assign normal = (dev_reg == sdc_pkg::DV_NORMAL);
   assign hold   = normal && !cke_prev_reg;
   assign live   = normal && cke_prev_reg;
   assign wake   = !cke_prev_reg && CKE;
   assign all_idle = &idle_mask;

   // Command legality against the addressed bank and the device mode
   always_comb begin
      bad = 1'b0;
      case (dev_reg)
         sdc_pkg::DV_NORMAL: begin
            if (cke_prev_reg) begin
               case (cmd)
                  sdc_pkg::CMD_MRS,
                  sdc_pkg::CMD_REF:  bad = !all_idle;
                  sdc_pkg::CMD_ACT:  bad = (bank_st[BA] != sdc_pkg::BK_IDLE);
                  sdc_pkg::CMD_RD,
                  sdc_pkg::CMD_WR:   bad = no_col_mask[BA];
                  sdc_pkg::CMD_PRE:  bad = |(ap_mask & pre_hit);
                  sdc_pkg::CMD_STOP: bad = bst_active_reg && bst_ap_reg;
                  default:           bad = 1'b0;
               endcase
            end
         end
         sdc_pkg::DV_MODE:    bad = !idle_cmd;
         sdc_pkg::DV_REFRESH: bad = !idle_cmd && (cmd != sdc_pkg::CMD_STOP);
         sdc_pkg::DV_SELF:    bad = wake && !idle_cmd;
         sdc_pkg::DV_PDOWN:   bad = wake && !CS_N;
         default:             bad = 1'b0;
      endcase
   end

   // Illegal commands are flagged and otherwise ignored
   assign go       = live && !bad;
   assign start    = go && ((cmd == sdc_pkg::CMD_RD) || (cmd == sdc_pkg::CMD_WR));
   assign stop_hit = go && (cmd == sdc_pkg::CMD_STOP) && bst_active_reg;
   assign pre_cut  = go && (cmd == sdc_pkg::CMD_PRE) && bst_active_reg && pre_hit[bst_bank_reg];
   assign bst_end  = bst_active_reg && (start || stop_hit || pre_cut || (!hold && bst_left_reg == LEN_W'(1)));

   // Flag, registered
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ILLEGAL_CMD <= 1'b0;
      end else begin
         ILLEGAL_CMD <= bad;
      end
   end

   // Device mode sequencing
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dev_reg     <= sdc_pkg::DV_NORMAL;
         dev_cnt_reg <= '0;
      end else begin
         case (dev_reg)
            sdc_pkg::DV_NORMAL: begin
               if (go && all_idle) begin
                  if (cmd == sdc_pkg::CMD_REF) begin
                     dev_reg     <= CKE ? sdc_pkg::DV_REFRESH : sdc_pkg::DV_SELF;
                     dev_cnt_reg <= sdc_pkg::RFC_LOAD;
                  end else if (cmd == sdc_pkg::CMD_MRS) begin
                     dev_reg     <= sdc_pkg::DV_MODE;
                     dev_cnt_reg <= sdc_pkg::MRS_LOAD;
                  end else if (idle_cmd && !CKE) begin
                     dev_reg <= sdc_pkg::DV_PDOWN;
                  end
               end
            end
            sdc_pkg::DV_MODE,
            sdc_pkg::DV_REFRESH: begin
               if (dev_cnt_reg == '0) begin
                  dev_reg <= sdc_pkg::DV_NORMAL;
               end else begin
                  dev_cnt_reg <= dev_cnt_reg - 1'b1;
               end
            end
            sdc_pkg::DV_SELF: begin
               // Clock enable held low simply stays here
               if (wake && idle_cmd) begin
                  dev_reg <= sdc_pkg::DV_NORMAL;
               end
            end
            sdc_pkg::DV_PDOWN: begin
               if (wake && CS_N) begin
                  dev_reg <= sdc_pkg::DV_NORMAL;
               end
            end
            default: dev_reg <= sdc_pkg::DV_NORMAL;
         endcase
      end
   end

   assign SELF_REFRESH = (dev_reg == sdc_pkg::DV_SELF);
   assign POWER_DOWN   = (dev_reg == sdc_pkg::DV_PDOWN);

   // One state machine per bank
   for (genvar i = 0; i < sdc_pkg::BANKS; i++) begin : g_bank
      sdc_pkg::sdc_bank_t        st_reg;
      logic [sdc_pkg::CNT_W-1:0] ras_reg; // Cycles left of minimum open time
      logic [sdc_pkg::CNT_W-1:0] pre_reg; // Cycles left until idle
      logic                      me;
      logic                      ended;

      assign me         = (int'(BA) == i);
      assign ended      = bst_end && (int'(bst_bank_reg) == i);
      assign pre_hit[i] = ADDR[sdc_pkg::AP_BIT] || me;
      assign bank_st[i] = st_reg;
      assign idle_mask[i] = (st_reg == sdc_pkg::BK_IDLE);
      assign ap_mask[i]   = (st_reg == sdc_pkg::BK_READ_AP) || (st_reg == sdc_pkg::BK_WRITE_AP);
      assign no_col_mask[i] = idle_mask[i] || ap_mask[i] || (st_reg == sdc_pkg::BK_PRECH);

      // Early precharge waits out the rest of the minimum open time
      always_ff @(posedge CLK or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            st_reg  <= sdc_pkg::BK_IDLE;
            ras_reg <= '0;
            pre_reg <= '0;
         end else if (!hold) begin
            if (ras_reg != '0) begin
               ras_reg <= ras_reg - 1'b1;
            end
            case (st_reg)
               sdc_pkg::BK_IDLE: begin
                  if (go && cmd == sdc_pkg::CMD_ACT && me) begin
                     st_reg  <= sdc_pkg::BK_ACTIVE;
                     ras_reg <= sdc_pkg::RAS_LOAD;
                  end
               end
               sdc_pkg::BK_ACTIVE,
               sdc_pkg::BK_READ,
               sdc_pkg::BK_WRITE: begin
                  if (start && me) begin
                     if (cmd == sdc_pkg::CMD_WR) begin
                        st_reg <= ADDR[sdc_pkg::AP_BIT] ? sdc_pkg::BK_WRITE_AP : sdc_pkg::BK_WRITE;
                     end else begin
                        st_reg <= ADDR[sdc_pkg::AP_BIT] ? sdc_pkg::BK_READ_AP : sdc_pkg::BK_READ;
                     end
                  end else if (go && cmd == sdc_pkg::CMD_PRE && pre_hit[i]) begin
                     st_reg  <= sdc_pkg::BK_PRECH;
                     pre_reg <= sdc_pkg::RP_LOAD + ras_reg;
                  end else if (ended) begin
                     st_reg <= sdc_pkg::BK_ACTIVE;
                  end
               end
               sdc_pkg::BK_READ_AP,
               sdc_pkg::BK_WRITE_AP: begin
                  if (ended) begin
                     st_reg  <= sdc_pkg::BK_PRECH;
                     pre_reg <= sdc_pkg::RP_LOAD + ras_reg;
                  end
               end
               sdc_pkg::BK_PRECH: begin
                  if (pre_reg == '0) begin
                     st_reg <= sdc_pkg::BK_IDLE;
                  end else begin
                     pre_reg <= pre_reg - 1'b1;
                  end
               end
               default: st_reg <= sdc_pkg::BK_IDLE;
            endcase
         end
      end
   end

   // Burst engine; only one burst owns the data pins at a time
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         bst_active_reg <= 1'b0;
         bst_write_reg  <= 1'b0;
         bst_ap_reg     <= 1'b0;
         bst_bank_reg   <= '0;
         bst_col_reg    <= '0;
         bst_left_reg   <= '0;
      end else if (start) begin
         bst_active_reg <= 1'b1;
         bst_write_reg  <= (cmd == sdc_pkg::CMD_WR);
         bst_ap_reg     <= ADDR[sdc_pkg::AP_BIT];
         bst_bank_reg   <= BA;
         bst_col_reg    <= ADDR[sdc_pkg::COL_W-1:0] + 1'b1;
         bst_left_reg   <= LEN_W'(BURST_LEN - 1);
      end else if (stop_hit || pre_cut) begin
         bst_active_reg <= 1'b0;
      end else if (bst_active_reg && !hold) begin
         bst_col_reg  <= bst_col_reg + 1'b1;
         bst_left_reg <= bst_left_reg - 1'b1;
         if (bst_left_reg == LEN_W'(1)) begin
            bst_active_reg <= 1'b0;
         end
      end
   end

   // A stop skips this cycle's beat: writes end now, reads drain the pipe
   assign acc_v    = start || (bst_active_reg && !hold && !stop_hit && !pre_cut);
   assign acc_wr   = start ? (cmd == sdc_pkg::CMD_WR) : bst_write_reg;
   assign acc_bank = start ? BA : bst_bank_reg;
   assign acc_col  = start ? ADDR[sdc_pkg::COL_W-1:0] : bst_col_reg;
   assign rd_issue = acc_v && !acc_wr;

   // Fully masked beats never reach the buffer; masked bytes enter with enables off
   assign wb_in.bank  = acc_bank;
   assign wb_in.col   = acc_col;
   assign wb_in.be    = ~DQM;
   assign wb_in.data  = DQ_IN;
   assign wb_in_valid = acc_v && acc_wr && (DQM != '1);

   // Reads own the array port, so a read stream stalls the drain
   assign drain  = wb_out_valid && !rd_issue;
   assign wb_out = sdc_pkg::sdc_wbuf_t'(wb_out_bits);

   sdc_fifo #(
      .WIDTH (WB_W),
      .DEPTH (sdc_pkg::WBUF_DEPTH)
   ) u_wbuf (
      .clk       (CLK),
      .rst_n     (rst_n_reg),
      .in_valid  (wb_in_valid),
      .in_ready  (WBUF_READY),
      .in_data   (wb_in),
      .out_valid (wb_out_valid),
      .out_ready (!rd_issue),
      .out_data  (wb_out_bits)
   );

   // Cell array, byte writes
   always_ff @(posedge CLK) begin
      if (drain) begin
         for (int b = 0; b < sdc_pkg::BYTES; b++) begin
            if (wb_out.be[b]) begin
               mem[{wb_out.bank, wb_out.col}][8*b +: 8] <= wb_out.data[8*b +: 8];
            end
         end
      end
   end

   // Read pipe of CAS_LAT stages, frozen while suspended
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rd_v_reg <= '0;
         for (int k = 0; k < CAS_LAT; k++) begin
            rd_data_reg[k] <= '0;
         end
      end else if (!hold) begin
         rd_v_reg       <= {rd_v_reg[CAS_LAT-2:0], rd_issue};
         rd_data_reg[0] <= mem[{acc_bank, acc_col}];
         for (int k = 1; k < CAS_LAT; k++) begin
            rd_data_reg[k] <= rd_data_reg[k-1];
         end
      end
   end

   // Read mask acts two clocks after it is sampled
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dqm_d1_reg <= '0;
         dqm_d2_reg <= '0;
      end else if (!hold) begin
         dqm_d1_reg <= DQM;
         dqm_d2_reg <= dqm_d1_reg;
      end
   end

   assign DQ_OUT = rd_data_reg[CAS_LAT-1];
   assign DQ_OE  = {sdc_pkg::BYTES{rd_v_reg[CAS_LAT-1]}} & ~dqm_d2_reg;

endmodule : sdc_core

`default_nettype wire

/* hw/sdc_pkg.sv */
// Purpose: shared constants and types for the SDRAM command and bank state logic
// Assumes: one 250 MHz clock; host pins are synchronous to it
// Notes:   nanosecond figures become cycle counts here, rounded up
// How it works
// - Chip select low decodes row, column, write strobes; chip select high deselects.
// - Burst stop ends writes at once, reads after the column-strobe latency.
// - Clock enable low freezes the core and stretches bursts, one clock late.
// - Read mask high turns the addressed bytes to high impedance two clocks later.
// - Write mask high blocks that cycle's byte write; low lets it through.
// - Self refresh ends on clock enable high with deselect or no operation only.
// - Power down ends on clock enable high with chip select high; banks idle.
// - Clock enable falling starts suspend next cycle; rising ends it next cycle.
// - Refresh with all idle auto-refreshes, or self-refreshes when clock enable low.
// - Idle bank: activate opens row; read or write illegal; deselect may power down.
// - Open row: read or write bursts, autoclose by address bit ten; precharge closes.
// - Plain burst: precharge ends and precharges, stop ends, idle commands continue.
// - Plain burst: a new read or write cuts it and restarts at the new column.
// - Two bank select bits pick one of four banks for activate, read, write.
// - After mode set the device is idle two clocks later; only idle commands meanwhile.
`default_nettype none

package sdc_pkg;

   // Geometry
   localparam int BANKS   = 4;
   localparam int BA_W    = 2;
   localparam int ADDR_W  = 12;
   localparam int COL_W   = 9;
   localparam int DATA_W  = 32;
   localparam int BYTES   = 4;
   localparam int AP_BIT  = 10;
   localparam int CNT_W   = 6;
   localparam int WBUF_DEPTH = 16;

   // Timing in its own unit
   localparam int CLK_PS     = 4000;
   localparam int T_RP_NS    = 20;
   localparam int T_RAS_NS   = 50;
   localparam int T_RFC_NS   = 70;
   localparam int MRS_CYC    = 2;
   localparam int DQM_RD_LAT = 2;

   // Minimum times round up to whole cycles, never below one
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc

   localparam int RP_CYC  = ns2cyc(T_RP_NS);
   localparam int RAS_CYC = ns2cyc(T_RAS_NS);
   localparam int RFC_CYC = ns2cyc(T_RFC_NS);

   // Counter loads, one less since the loading edge counts
   localparam logic [CNT_W-1:0] RP_LOAD  = CNT_W'(RP_CYC - 1);
   localparam logic [CNT_W-1:0] RAS_LOAD = CNT_W'(RAS_CYC - 1);
   localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(RFC_CYC - 1);
   localparam logic [CNT_W-1:0] MRS_LOAD = CNT_W'(MRS_CYC - 1);

   // Reset values
   localparam logic CKE_PREV_RST = 1'b1;

   // Decoded command: {0, ras_n, cas_n, we_n}, deselect apart
   typedef enum logic [3:0] {
      CMD_MRS   = 4'h0,
      CMD_REF   = 4'h1,
      CMD_PRE   = 4'h2,
      CMD_ACT   = 4'h3,
      CMD_WR    = 4'h4,
      CMD_RD    = 4'h5,
      CMD_STOP  = 4'h6,
      CMD_NOP   = 4'h7,
      CMD_DESEL = 4'h8
   } sdc_cmd_t;

   // Per-bank state
   typedef enum logic [2:0] {
      BK_IDLE     = 3'h0,
      BK_ACTIVE   = 3'h1,
      BK_READ     = 3'h3,
      BK_WRITE    = 3'h2,
      BK_READ_AP  = 3'h7,
      BK_WRITE_AP = 3'h6,
      BK_PRECH    = 3'h4
   } sdc_bank_t;

   // Whole-device mode
   typedef enum logic [2:0] {
      DV_NORMAL  = 3'h0,
      DV_MODE    = 3'h1,
      DV_REFRESH = 3'h3,
      DV_SELF    = 3'h2,
      DV_PDOWN   = 3'h6
   } sdc_dev_t;

   // One buffered write
   typedef struct packed {
      logic [BA_W-1:0]   bank;
      logic [COL_W-1:0]  col;
      logic [BYTES-1:0]  be;
      logic [DATA_W-1:0] data;
   } sdc_wbuf_t;

endpackage : sdc_pkg

`default_nettype wire

/* hw/sdc_fifo.sv */
// Purpose: write buffer between the burst engine and the cell array
// Assumes: DEPTH is a power of two
// Notes:   pointers carry one extra bit to tell full from empty
`default_nettype none

module sdc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = sdc_pkg::WBUF_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] buf_mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;

   // Full when the wrap bits differ and the rest match
   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
   assign out_data  = buf_mem[rd_ptr_reg[AW-1:0]];

   // Pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         buf_mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule : sdc_fifo

`default_nettype wire

/* test/sdc_core_chk.sv */
// Purpose: pin-level checks on the SDRAM core
// Assumes: CAS latency 2; lane 1 carries the read-mask case
// Notes:   flag, read-mask, wake-up, suspend and mode-wait behaviour only
`default_nettype none
module sdc_core_chk (
   // Clock, reset, commands
   input wire logic       CLK,
   input wire logic       NRST,
   input wire logic       CKE,
   input wire logic       CS_N,
   input wire logic       RAS_N,
   input wire logic       CAS_N,
   input wire logic       WE_N,
   // Data and status
   input wire logic [3:0] DQM,
   input wire logic [31:0] DQ_OUT,
   input wire logic [3:0] DQ_OE,
   input wire logic       ILLEGAL_CMD,
   input wire logic       SELF_REFRESH,
   input wire logic       POWER_DOWN
);
   logic [3:0] cmd;
   logic       awake;
   // Low-power modes handle CKE themselves, so suspend checks skip them
   assign cmd = {CS_N, RAS_N, CAS_N, WE_N};
   assign awake = !SELF_REFRESH && !POWER_DOWN;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_flag_select: assert property (ILLEGAL_CMD |-> $past(CS_N) == 1'b0) else $error("flag without command");
   a_frozen_quiet: assert property (awake && !$past(CKE) |=> !ILLEGAL_CMD) else $error("frozen edge flagged");
   a_frozen_data: assert property (awake && !$past(CKE) |=> $stable(DQ_OUT) && $stable(DQ_OE))
      else $error("data moved in suspend");
   a_rd_mask: assert property ($past(CKE) && CKE && DQM[1] ##1 CKE |=> !DQ_OE[1]) else $error("mask ignored");
   a_mrs_wait: assert property (CKE && $past(CKE) && awake && cmd == 4'h0 ##1 !ILLEGAL_CMD && cmd == 4'h5
      |=> ILLEGAL_CMD) else $error("read in mode wait");
   a_self_hold: assert property (SELF_REFRESH && !CKE |=> SELF_REFRESH) else $error("self refresh lost");
   a_self_exit: assert property (SELF_REFRESH && !$past(CKE) && CKE && (CS_N || cmd == 4'h7)
      |=> !SELF_REFRESH) else $error("no self refresh exit");
   a_pd_wake: assert property (POWER_DOWN && !$past(CKE) && CKE && !CS_N |=> ILLEGAL_CMD) else $error("bad wake");
endmodule : sdc_core_chk
bind sdc_core sdc_core_chk chk_u (.CLK(CLK), .NRST(NRST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
   .WE_N(WE_N), .DQM(DQM), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ILLEGAL_CMD(ILLEGAL_CMD),
   .SELF_REFRESH(SELF_REFRESH), .POWER_DOWN(POWER_DOWN));
`default_nettype wire

/* test/sdc_host.sv */
// Purpose: host controller model driving the core's command pins
// Assumes: bench calls its tasks; pins change at the falling edge
// Notes:   idle data toggles so a stale beat never matches
`default_nettype none
module sdc_host (
   // Clock
   input wire logic        CLK,
   // Pins toward the core
   output var logic        CKE,
   output var logic [3:0]  CMD_N,
   output var logic [1:0]  BA,
   output var logic [11:0] ADDR,
   output var logic [3:0]  DQM,
   output var logic [31:0] DQ_IN
);
   // Quiet pins from time zero
   initial begin
      CKE = 1'b1;
      CMD_N = sdc_pkg::CMD_DESEL;
      BA = 2'h0;
      ADDR = 12'h000;
      DQM = 4'h0;
      DQ_IN = 32'h0;
   end
   // One command per cycle, held until the next call
   task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [3:0] m,
                     input logic [31:0] d);
      @(negedge CLK);
      CMD_N = c;
      BA = b;
      ADDR = a;
      DQM = m;
      DQ_IN = d;
   endtask : op
   // Command without data: lanes open, data toggled so nothing stale matches
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      op(c, b, a, 4'h0, ~DQ_IN);
   endtask : cmd
   // Bank and address are held, since a no operation ignores them
   task automatic nop(input int n);
      repeat (n) cmd(sdc_pkg::CMD_NOP, BA, ADDR);
   endtask : nop
endmodule : sdc_host
`default_nettype wire

/* test/test_sdram_command_state_logic.sv */
// Purpose: self-checking bench for the SDRAM core
// Assumes: burst of four, CAS latency 2, 4 ns clock
// Notes:   waits follow the minimum timings in whole cycles
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_sdram_command_state_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK, NRST, CKE, ILLEGAL_CMD, SELF_REFRESH, POWER_DOWN, WBUF_READY;
   logic [3:0] cmd_n, DQM, DQ_OE;
   logic [1:0] BA;
   logic [11:0] ADDR;
   logic [31:0] DQ_IN, DQ_OUT;
   int n_fail = 0, total_checks = 0;
   sdc_host h_u (.CLK(CLK), .CKE(CKE), .CMD_N(cmd_n), .BA(BA), .ADDR(ADDR), .DQM(DQM), .DQ_IN(DQ_IN));
   sdc_core #(.BURST_LEN(4), .CAS_LAT(2)) dut_u (.CLK(CLK), .NRST(NRST), .CKE(CKE), .CS_N(cmd_n[3]),
      .RAS_N(cmd_n[2]), .CAS_N(cmd_n[1]), .WE_N(cmd_n[0]), .BA(BA), .ADDR(ADDR), .DQM(DQM), .DQ_IN(DQ_IN),
      .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ILLEGAL_CMD(ILLEGAL_CMD), .SELF_REFRESH(SELF_REFRESH),
      .POWER_DOWN(POWER_DOWN), .WBUF_READY(WBUF_READY));
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // Idle bank refuses columns; mode set forbids commands for two clocks
   task automatic t_idle();
      h_u.cmd(sdc_pkg::CMD_RD, 2'h1, 12'h000);
      h_u.cmd(sdc_pkg::CMD_MRS, 2'h0, 12'h020);
      `CHK(ILLEGAL_CMD, 1'b1)
      h_u.cmd(sdc_pkg::CMD_RD, 2'h0, 12'h000);
      `CHK(ILLEGAL_CMD, 1'b0)
      h_u.nop(1);
      `CHK(ILLEGAL_CMD, 1'b1)
      h_u.nop(2);
   endtask : t_idle
   // Four beats to bank 2 from column 8; full buffer would drop beats
   task automatic wr_burst(input logic [31:0] base, input logic [3:0] m);
      int i;
      for (i = 0; i < 50 && WBUF_READY !== 1'b1; i++) @(negedge CLK);
      if (i == 50) begin
         n_fail++;
         finish_test();
      end
      for (i = 0; i < 4; i++) h_u.op(i == 0 ? sdc_pkg::CMD_WR : sdc_pkg::CMD_NOP, 2'h2, 12'h008, m, base + i);
   endtask : wr_burst
   // Write, masked rewrite, autoclosing masked read-back with one suspended edge, then precharge
   task automatic t_data();
      logic [31:0] a, b, e;
      int j, k;
      a = 32'ha0a1a2a0;
      b = 32'hb5c6d700;
      h_u.cmd(sdc_pkg::CMD_ACT, 2'h2, 12'h123);
      h_u.nop(1);
      `CHK(ILLEGAL_CMD, 1'b0)
      h_u.nop(3);
      wr_burst(a, 4'h0);
      h_u.nop(2);
      wr_burst(b, 4'h1);
      h_u.nop(20);
      h_u.op(sdc_pkg::CMD_RD, 2'h2, 12'h408, 4'h2, ~h_u.DQ_IN);
      h_u.nop(1);
      // Clock enable low for one edge mid-burst: the second beat stands twice
      for (j = 0; j < 5; j++) begin
         h_u.nop(1);
         if (j < 2) h_u.CKE = (j == 1);
         k = (j < 2) ? j : j - 1;
         e = ((b + k) & 32'hffffff00) | ((a + k) & 32'h000000ff);
         `CHK(DQ_OUT & (j == 0 ? 32'hffff00ff : 32'hffffffff), e & (j == 0 ? 32'hffff00ff : 32'hffffffff))
         `CHK(DQ_OE, j == 0 ? 4'hd : 4'hf)
      end
      h_u.nop(1);
      `CHK(DQ_OE, 4'h0)
      h_u.cmd(sdc_pkg::CMD_PRE, 2'h0, 12'h400);
      h_u.nop(20);
   endtask : t_data
   // Self refresh entry and exit, then power down with a bad wake-up
   task automatic t_low();
      h_u.cmd(sdc_pkg::CMD_REF, 2'h0, 12'h000);
      h_u.CKE = 1'b0;
      h_u.nop(4);
      `CHK(SELF_REFRESH, 1'b1)
      h_u.nop(1);
      h_u.CKE = 1'b1;
      h_u.nop(1);
      `CHK(SELF_REFRESH, 1'b0)
      h_u.nop(18);
      h_u.CKE = 1'b0;
      h_u.nop(2);
      `CHK(POWER_DOWN, 1'b1)
      h_u.cmd(sdc_pkg::CMD_ACT, 2'h0, 12'h000);
      h_u.CKE = 1'b1;
      h_u.nop(1);
      `CHK(ILLEGAL_CMD, 1'b1)
      h_u.CKE = 1'b0;
      h_u.cmd(sdc_pkg::CMD_DESEL, 2'h0, 12'h000);
      h_u.CKE = 1'b1;
      h_u.nop(2);
      `CHK(POWER_DOWN, 1'b0)
   endtask : t_low
   // Clock
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   // Main sequence
   initial begin
      NRST = 1'b0;
      repeat (12) @(negedge CLK);
      NRST = 1'b1;
      h_u.nop(3);
      t_idle();
      t_data();
      t_low();
      finish_test();
   end
endmodule : test_sdram_command_state_logic
`default_nettype wire
